// ===== inc/sysctl_params.svh
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// register byte addresses on the serial slave port
`define ADDR_INT_MASK_LO 8'h14
`define ADDR_INT_MASK_HI 8'h15
`define ADDR_HW_CTRL_LO 8'h18
`define ADDR_HW_CTRL_HI 8'h19
`define ADDR_SLAVE_ADDR 8'h1a
`define ADDR_PWR_BUSY 8'h1b
`define ADDR_LEVEL_LO 8'h20
`define ADDR_LEVEL_HI 8'h21
`define ADDR_CHANGE_LO 8'h22
`define ADDR_CHANGE_HI 8'h23
`define ADDR_LINE_EN_LO 8'h24
`define ADDR_LINE_EN_HI 8'h25

// reset values and writable mask
`define INT_MASK_RESET 16'h1040
`define INT_MASK_WRITABLE 16'h57ff
`define HW_CTRL_RESET 16'h0008
`define CHANGE_RESET 16'h0000
`define LINE_EN_RESET 16'h0000

// field positions
`define HW_GEN_CALL 5
`define HW_FAST 3
`define HW_READY 2
`define HW_UPDATE 1
`define HW_SOFT_CHIP_RESET 0
`define INT_LINE_BIT 1
`define INT_READY_BIT 12
`define ADDR_FIELD_W 7
`define OUT_ONLY_A 1
`define OUT_ONLY_B 10
`define ALT_LOW 9

// configuration time after reset, in cycles
`define CONFIG_CYCLES 8'h10

`endif

// ===== inc/sysctl_pkg.sv
package sysctl_pkg;
    typedef enum logic [1:0] {
        st_config,
        st_idle,
        st_copy
    } ctl_state_t;
endpackage

// ===== hw/line_sync.sv
`timescale 1ns/10ps
`include "sysctl_params.svh"
// three-stage synchroniser; value accepted when stages two and three agree
module line_sync (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // lines
    input wire logic [15:0] raw_i,
    output logic [15:0] level_o
);
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] next_level;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : gen_bit
            assign next_level[g] = (s2[g] == s3[g]) ? s3[g] : level_o[g];
        end
    endgenerate

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1 <= 16'h0000;
            s2 <= 16'h0000;
            s3 <= 16'h0000;
            level_o <= 16'h0000;
        end else begin
            s1 <= raw_i;
            s2 <= s1;
            s3 <= s2;
            level_o <= next_level;
        end
    end
endmodule // line_sync

// ===== hw/system_control_regs.sv
`timescale 1ns/10ps
`include "sysctl_params.svh"
// Functional notes
// R1: cleared mask bit blocks interrupt; 15,13,11 read-only
// R2: control bit 5 accepts general call
// R3: control bit 3 fastest speed, resets 1
// R4: ready flag set after configuration completes
// R5: bit 1 copies shadows, then self-clears
// R6: copy waits while any override pending
// R7: bit 0 starts chip reset, self-clears
// R8: 7-bit slave address, reset from strap
// R9: busy flag high while power write pending
// R10: host waits for busy low before writing
// R11: level register shows sixteen line levels
// R12: line change sets status bit n
// R13: write one clears bit, re-arms detection
// R14: enabled set status bit raises line interrupt
// R15: lines 1 and 10 outputs, low at reset
// R16: role modes give lines 9-15 alternate functions
// R17: top status bit 1 is line interrupt
// R18: top status bit 12 mirrors ready flag
// R19: per-line enable register gates change interrupts
// R20: interrupt out when status and mask overlap
module system_control_regs
    import sysctl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // byte register port from the serial slave
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // straps and status from other blocks
    input wire logic [6:0] address_strap_pin_i,
    input wire logic power_ctrl_busy_i,
    input wire logic [15:0] line_override_enable_i,
    input wire logic [15:0] other_int_status_i,
    input wire logic downstream_facing_role_i,
    input wire logic upstream_facing_role_i,
    // general purpose lines
    input wire logic [15:0] line_pin_i,
    output logic output_only_line_a_o,
    output logic output_only_line_b_o,
    output logic [15:0] line_gp_active_o,
    // controls to other blocks
    output logic general_call_accept_o,
    output logic fastest_speed_select_o,
    output logic [6:0] slave_address_o,
    output logic shadow_copy_strobe_o,
    output logic soft_chip_reset_o,
    output logic config_done_flag_o,
    output logic top_interrupt_o
);
    logic [15:0] interrupt_mask;
    logic [15:0] hardware_control;
    logic [6:0] serial_slave_address;
    logic power_ctrl_write_busy;
    logic [15:0] line_change_status;
    logic [15:0] line_interrupt_enable;
    logic [15:0] line_level;
    logic [15:0] level_prev;
    logic strap_taken;
    logic [7:0] cfg_count;
    ctl_state_t state;
    ctl_state_t next_state;

    function automatic logic [15:0] write_word(input logic [15:0] cur,
            input logic lo_hit, input logic hi_hit, input logic [7:0] data);
        logic [15:0] res;
        res = cur;
        if (lo_hit) begin
            res[7:0] = data;
        end
        if (hi_hit) begin
            res[15:8] = data;
        end
        return res;
    endfunction

    line_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .raw_i(line_pin_i),
        .level_o(line_level)
    );

    // address decode
    wire wr_mask_lo = reg_wr_i && (reg_addr_i == `ADDR_INT_MASK_LO);
    wire wr_mask_hi = reg_wr_i && (reg_addr_i == `ADDR_INT_MASK_HI);
    wire wr_hw_lo = reg_wr_i && (reg_addr_i == `ADDR_HW_CTRL_LO);
    wire wr_slave = reg_wr_i && (reg_addr_i == `ADDR_SLAVE_ADDR);
    wire wr_chg_lo = reg_wr_i && (reg_addr_i == `ADDR_CHANGE_LO);
    wire wr_chg_hi = reg_wr_i && (reg_addr_i == `ADDR_CHANGE_HI);
    wire wr_en_lo = reg_wr_i && (reg_addr_i == `ADDR_LINE_EN_LO);
    wire wr_en_hi = reg_wr_i && (reg_addr_i == `ADDR_LINE_EN_HI);

    wire [15:0] next_mask = write_word(interrupt_mask, wr_mask_lo, wr_mask_hi, reg_wdata_i)
        & `INT_MASK_WRITABLE; // R1
    wire [15:0] next_line_en = write_word(line_interrupt_enable, wr_en_lo, wr_en_hi,
        reg_wdata_i); // R19

    // change detection, set wins over write-one clear
    wire [15:0] line_edge = line_level ^ level_prev; // R12
    wire [15:0] clear_bits = write_word(16'h0000, wr_chg_lo, wr_chg_hi, reg_wdata_i); // R13
    wire [15:0] next_change = (line_change_status & ~clear_bits) | line_edge; // R12

    wire line_int = |(line_change_status & line_interrupt_enable); // R14
    logic [15:0] top_status;
    always_comb begin
        top_status = other_int_status_i;
        top_status[`INT_LINE_BIT] = line_int; // R17
        top_status[`INT_READY_BIT] = hardware_control[`HW_READY]; // R18
    end
    wire next_top_int = |(top_status & interrupt_mask); // R1 R20

    wire update_req = wr_hw_lo && reg_wdata_i[`HW_UPDATE];
    wire override_pending = |line_override_enable_i;
    wire soft_chip_reset_req = wr_hw_lo && reg_wdata_i[`HW_SOFT_CHIP_RESET]; // R7

    always_comb begin
        next_state = state;
        case (state)
            st_config: begin
                if (cfg_count == `CONFIG_CYCLES) begin
                    next_state = st_idle; // R4
                end
            end
            st_idle: begin
                if (hardware_control[`HW_UPDATE] && !override_pending) begin
                    next_state = st_copy; // R6
                end
            end
            st_copy: next_state = st_idle;
            default: next_state = st_config;
        endcase
    end

    logic [15:0] next_hw;
    always_comb begin
        next_hw = hardware_control;
        if (wr_hw_lo) begin
            next_hw[`HW_GEN_CALL] = reg_wdata_i[`HW_GEN_CALL]; // R2
            next_hw[`HW_FAST] = reg_wdata_i[`HW_FAST]; // R3
        end
        // a request written in the copy cycle survives for the next copy
        if (state == st_copy) begin
            next_hw[`HW_UPDATE] = 1'b0; // R5
        end
        if (update_req) begin
            next_hw[`HW_UPDATE] = 1'b1; // R5
        end
        if (state == st_config && next_state == st_idle) begin
            next_hw[`HW_READY] = 1'b1; // R4
        end
        next_hw[`HW_SOFT_CHIP_RESET] = 1'b0; // R7
    end

    // lines 9-15 leave gp duty in either standalone role
    wire role_mode = downstream_facing_role_i || upstream_facing_role_i;
    wire [15:0] gp_active = role_mode ? (16'hffff >> (16 - `ALT_LOW)) : 16'hffff; // R16

    logic [7:0] next_rdata;
    always_comb begin
        case (reg_addr_i)
            `ADDR_INT_MASK_LO: next_rdata = interrupt_mask[7:0];
            `ADDR_INT_MASK_HI: next_rdata = interrupt_mask[15:8];
            `ADDR_HW_CTRL_LO: next_rdata = {2'b00, hardware_control[`HW_GEN_CALL], 1'b0,
                hardware_control[`HW_FAST], hardware_control[`HW_READY],
                hardware_control[`HW_UPDATE], 1'b0};
            `ADDR_HW_CTRL_HI: next_rdata = 8'h00;
            `ADDR_SLAVE_ADDR: next_rdata = {1'b0, serial_slave_address}; // R8
            `ADDR_PWR_BUSY: next_rdata = {7'h00, power_ctrl_write_busy}; // R9
            `ADDR_LEVEL_LO: next_rdata = line_level[7:0]; // R11
            `ADDR_LEVEL_HI: next_rdata = line_level[15:8]; // R11
            `ADDR_CHANGE_LO: next_rdata = line_change_status[7:0];
            `ADDR_CHANGE_HI: next_rdata = line_change_status[15:8];
            `ADDR_LINE_EN_LO: next_rdata = line_interrupt_enable[7:0];
            `ADDR_LINE_EN_HI: next_rdata = line_interrupt_enable[15:8];
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= st_config;
            cfg_count <= 8'h00;
            interrupt_mask <= `INT_MASK_RESET;
            hardware_control <= `HW_CTRL_RESET;
            serial_slave_address <= 7'h00;
            strap_taken <= 1'b0;
            line_interrupt_enable <= `LINE_EN_RESET;
            line_change_status <= `CHANGE_RESET;
            level_prev <= 16'h0000;
            power_ctrl_write_busy <= 1'b0;
            reg_rdata_o <= 8'h00;
            top_interrupt_o <= 1'b0;
            shadow_copy_strobe_o <= 1'b0;
            soft_chip_reset_o <= 1'b0;
            line_gp_active_o <= 16'hffff;
        end else begin
            state <= next_state;
            if (state == st_config) begin
                cfg_count <= cfg_count + 8'h01;
            end
            interrupt_mask <= next_mask;
            hardware_control <= next_hw;
            strap_taken <= 1'b1;
            if (!strap_taken) begin
                serial_slave_address <= address_strap_pin_i; // R8
            end else if (wr_slave) begin
                serial_slave_address <= reg_wdata_i[`ADDR_FIELD_W-1:0]; // R8
            end
            line_interrupt_enable <= next_line_en;
            line_change_status <= next_change;
            level_prev <= line_level;
            power_ctrl_write_busy <= power_ctrl_busy_i; // R9
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
            top_interrupt_o <= next_top_int;
            shadow_copy_strobe_o <= (state == st_copy); // R5
            soft_chip_reset_o <= soft_chip_reset_req; // R7
            line_gp_active_o <= gp_active;
        end
    end

    // output-only lines held low; nothing drives them high after release
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            output_only_line_a_o <= 1'b0; // R15
            output_only_line_b_o <= 1'b0; // R15
        end else begin
            output_only_line_a_o <= 1'b0;
            output_only_line_b_o <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            general_call_accept_o <= 1'b0;
            fastest_speed_select_o <= 1'b1;
            slave_address_o <= 7'h00;
            config_done_flag_o <= 1'b0;
        end else begin
            general_call_accept_o <= hardware_control[`HW_GEN_CALL];
            fastest_speed_select_o <= hardware_control[`HW_FAST];
            slave_address_o <= serial_slave_address;
            config_done_flag_o <= hardware_control[`HW_READY];
        end
    end
endmodule // system_control_regs

// ===== tb/system_control_regs_monitor.sv
`timescale 1ns/10ps
module sysctl_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // status and controls
    input wire logic power_ctrl_busy_i,
    input wire logic [15:0] line_override_enable_i,
    input wire logic output_only_line_a_o,
    input wire logic output_only_line_b_o,
    input wire logic shadow_copy_strobe_o,
    input wire logic soft_chip_reset_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    a_mask_reserved: assert property (reg_rd_i && reg_addr_i == 8'h15 |=>
        (reg_rdata_o & 8'ha8) == 8'h00) else $error("reserved mask bit reads one");
    a_copy_held: assert property ((|line_override_enable_i)[*3] |->
        !shadow_copy_strobe_o) else $error("copy while override pending");
    a_copy_pulse: assert property (shadow_copy_strobe_o |=>
        !shadow_copy_strobe_o) else $error("copy strobe too long");
    a_reset_start: assert property (reg_wr_i && reg_addr_i == 8'h18 && reg_wdata_i[0]
        |-> ##[1:2] soft_chip_reset_o) else $error("no chip reset pulse");
    a_reset_pulse: assert property (soft_chip_reset_o |=>
        !soft_chip_reset_o) else $error("chip reset pulse too long");
    a_reset_reads: assert property (reg_rd_i && reg_addr_i == 8'h18 |=>
        !reg_rdata_o[0]) else $error("reset bit reads one");
    a_busy_flag: assert property (reg_rd_i && reg_addr_i == 8'h1b && power_ctrl_busy_i
        && $past(power_ctrl_busy_i) && !$past(rst_i) |=> reg_rdata_o == 8'h01)
        else $error("busy flag not shown");
    a_out_low: assert property (!(output_only_line_a_o || output_only_line_b_o))
        else $error("output only line high");
endmodule // sysctl_monitor

bind system_control_regs sysctl_monitor mon (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .power_ctrl_busy_i(power_ctrl_busy_i),
    .line_override_enable_i(line_override_enable_i),
    .output_only_line_a_o(output_only_line_a_o),
    .output_only_line_b_o(output_only_line_b_o),
    .shadow_copy_strobe_o(shadow_copy_strobe_o),
    .soft_chip_reset_o(soft_chip_reset_o)
);

// ===== tb/host_model.sv
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic sys_clk_i,
    // byte register port
    output logic reg_wr_o = 0,
    output logic reg_rd_o = 0,
    output logic [7:0] reg_addr_o = 8'h00,
    output logic [7:0] reg_wdata_o = 8'h00,
    input wire logic [7:0] reg_rdata_i
);
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = v;
        reg_wr_o = 1;
        @(negedge sys_clk_i);
        reg_wr_o = 0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1;
        @(negedge sys_clk_i);
        reg_rd_o = 0;
        v = reg_rdata_i;
    endtask
    // poll until the power controller can take a new write
    task idle_wait;
        logic [7:0] v;
        v = 8'h01;
        for (int i = 0; i < 50 && v[0]; i++) begin
            rd(8'h1b, v);
        end
    endtask
endmodule // host_model

// ===== tb/system_control_regs_bench.sv
`timescale 1ns/10ps
module system_control_regs_bench;
    logic sys_clk_i = 0;
    logic rst_i = 1;
    logic busy = 0;
    logic [15:0] ovr = 16'h0000;
    logic [15:0] pins = 16'h0000;
    logic [6:0] strap = 7'h2d;
    logic downstream_facing_role = 0;
    logic upstream_facing_role = 0;
    logic gca, fss, cdf;
    logic [6:0] sla;
    logic [15:0] gpa;
    logic wr, rd, irq, strb;
    logic [7:0] addr, wdata, rdata, d, r;
    int fails = 0;
    int n_compared = 0;
    int n_strb = 0;
    int exp_q[$];

    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (strb === 1'b1) n_strb++;

    host_model host (.sys_clk_i(sys_clk_i), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_rdata_i(rdata));
    system_control_regs uut (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .address_strap_pin_i(strap),
        .power_ctrl_busy_i(busy),
        .line_override_enable_i(ovr),
        .other_int_status_i(16'h0000),
        .downstream_facing_role_i(downstream_facing_role),
        .upstream_facing_role_i(upstream_facing_role),
        .line_pin_i(pins),
        .output_only_line_a_o(),
        .output_only_line_b_o(),
        .line_gp_active_o(gpa),
        .general_call_accept_o(gca),
        .fastest_speed_select_o(fss),
        .slave_address_o(sla),
        .shadow_copy_strobe_o(strb),
        .soft_chip_reset_o(),
        .config_done_flag_o(cdf),
        .top_interrupt_o(irq)
    );

    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask
    task rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk(d, e);
    endtask
    task gap(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task print_verdict;
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        fails++;
        print_verdict();
    end

    initial begin
        void'($urandom(77280));
        gap(16);
        rst_i = 0;
        rc(8'h14, 8'h40);
        rc(8'h15, 8'h10);
        rc(8'h18, 8'h08);
        rc(8'h1a, {1'b0, strap});
        chk({1'b0, sla}, {1'b0, strap});
        chk({6'h0, gca, fss}, 8'h01);
        chk({7'h0, cdf}, 8'h00);
        rc(8'h22, 8'h00);
        gap(30);
        rc(8'h18, 8'h0c);
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, cdf}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            exp_q.push_back(r & 8'h57);
            host.wr(8'h15, r);
            rc(8'h15, 8'(exp_q.pop_front()));
        end
        host.wr(8'h15, 8'h00);
        gap(3);
        chk({7'h0, irq}, 8'h00);
        host.wr(8'h18, 8'h29);
        gap(3);
        rc(8'h18, 8'h2c);
        chk({6'h0, gca, fss}, 8'h03);
        r = 8'($urandom);
        host.wr(8'h1a, r);
        rc(8'h1a, r & 8'h7f);
        chk({1'b0, sla}, r & 8'h7f);
        downstream_facing_role = 1;
        gap(2);
        chk(gpa[15:8], 8'h01);
        downstream_facing_role = 0;
        upstream_facing_role = 1;
        gap(2);
        chk(gpa[15:8], 8'h01);
        upstream_facing_role = 0;
        gap(2);
        chk(gpa[15:8], 8'hff);
        chk(gpa[7:0], 8'hff);
        ovr = 16'h0010;
        host.wr(8'h18, 8'h2a);
        gap(4);
        rc(8'h18, 8'h2e);
        chk(n_strb[7:0], 8'h00);
        ovr = 16'h0000;
        gap(5);
        rc(8'h18, 8'h2c);
        chk(n_strb[7:0], 8'h01);
        pins = 16'($urandom) | 16'h0101;
        gap(10);
        rc(8'h20, pins[7:0]);
        rc(8'h21, pins[15:8]);
        rc(8'h22, pins[7:0]);
        host.wr(8'h24, 8'hff);
        host.wr(8'h14, 8'h02);
        gap(3);
        chk({7'h0, irq}, 8'h01);
        host.wr(8'h22, 8'hff);
        gap(3);
        rc(8'h22, 8'h00);
        rc(8'h23, pins[15:8]);
        chk({7'h0, irq}, 8'h00);
        host.wr(8'h25, 8'hff);
        gap(3);
        chk({7'h0, irq}, 8'h01);
        pins = pins ^ 16'h0001;
        gap(10);
        rc(8'h22, 8'h01);
        busy = 1;
        gap(2);
        rc(8'h1b, 8'h01);
        busy = 0;
        host.idle_wait();
        rc(8'h1b, 8'h00);
        rst_i = 1;
        gap(2);
        rst_i = 0;
        rc(8'h14, 8'h40);
        rc(8'h18, 8'h08);
        rc(8'h1a, {1'b0, strap});
        chk({6'h0, gca, fss}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        rc(8'h30, 8'h00);
        print_verdict();
    end
endmodule // system_control_regs_bench
